// File: pkg/rss_defines.vh
`ifndef RSS_DEFINES_VH
`define RSS_DEFINES_VH

// register byte offsets
`define RSS_OFF_CTRL 12'h000
`define RSS_OFF_INSTR 12'h004
`define RSS_OFF_WREG 12'h008
`define RSS_OFF_STAT 12'h00C
`define RSS_OFF_BANK 12'h010
`define RSS_OFF_INDEX 12'h014
`define RSS_OFF_PWR 12'h018
`define RSS_OFF_FADDR 12'h01C
`define RSS_OFF_FDATA 12'h020
`define RSS_OFF_WDOG 12'h024

// control bits
`define RSS_CTRL_EXT 0
`define RSS_CTRL_WDE 1

// status flag positions
`define RSS_ST_C 0
`define RSS_ST_DC 1
`define RSS_ST_Z 2
`define RSS_ST_OV 3
`define RSS_ST_N 4

// power status positions
`define RSS_PWR_SLEEP 0
`define RSS_PWR_TO 1
`define RSS_PWR_PD 2
`define RSS_PWR_BUSY 3
`define RSS_PWR_PEND 4

// opcode fields
`define RSS_OPC_RRC 6'h0C
`define RSS_OPC_RRN 6'h10
`define RSS_OPC_SFB 6'h15
`define RSS_OPC_SET 7'h34
`define RSS_INS_SLEEP 16'h0003
`define RSS_BIT_D 9
`define RSS_BIT_A 8

// instruction kinds
`define RSS_K_NONE 3'h0
`define RSS_K_RRC 3'h1
`define RSS_K_RRN 3'h2
`define RSS_K_SET 3'h3
`define RSS_K_SFB 3'h4
`define RSS_K_SLP 3'h5

// addressing
`define RSS_LIT_LIMIT 8'h5F
`define RSS_ACC_HIGH 4'hF
`define RSS_ACC_LOW 4'h0

// quarter phases
`define RSS_Q1 2'h0
`define RSS_Q2 2'h1
`define RSS_Q3 2'h2
`define RSS_Q4 2'h3

// reset values, and the fill-with-ones byte
`define RSS_RST_CTRL 2'h0
`define RSS_RST_STAT 5'h00
`define RSS_RST_BYTE 8'h00
`define RSS_ONES 8'hFF

`endif

// File: rtl/rss_addr.v
`include "rss_defines.vh"

module rss_addr (
  input wire [7:0] f_field,
  input wire acc_sel,
  input wire ext_en,
  input wire [3:0] bank,
  input wire [11:0] index_base,
  output reg [11:0] file_addr
);
  reg [11:0] offs;

  always @* begin
    offs = {4'h0, f_field};
    if (acc_sel) begin
      file_addr = {bank, f_field};
    end else if (ext_en && f_field <= `RSS_LIT_LIMIT) begin
      // wraps inside the file space, no range check
      file_addr = index_base + offs;
    end else if (f_field <= `RSS_LIT_LIMIT) begin
      file_addr = {`RSS_ACC_LOW, f_field};
    end else begin
      file_addr = {`RSS_ACC_HIGH, f_field};
    end
  end
endmodule

// File: rtl/rss_alu.v
`include "rss_defines.vh"

module rss_alu (
  input wire [2:0] kind,
  input wire [7:0] opnd,
  input wire [7:0] wval,
  input wire cin,
  output reg [7:0] res,
  output reg [4:0] flags,
  output reg [4:0] upd
);
  reg [8:0] diff;
  reg [4:0] half;

  always @* begin
    diff = {1'b0, wval} + {1'b0, ~opnd} + {8'h00, cin};
    half = {1'b0, wval[3:0]} + {1'b0, ~opnd[3:0]} + {4'h0, cin};
    res = opnd;
    flags = 5'h00;
    upd = 5'h00;
    case (kind)
      `RSS_K_RRC: begin
        res = {cin, opnd[7:1]};
        flags[`RSS_ST_C] = opnd[0];
        upd = 5'h15;
      end
      `RSS_K_RRN: begin
        res = {opnd[0], opnd[7:1]};
        upd = 5'h14;
      end
      `RSS_K_SET: begin
        res = `RSS_ONES;
      end
      `RSS_K_SFB: begin
        // w + ~f + c equals w - f - !c
        res = diff[7:0];
        flags[`RSS_ST_C] = diff[8];
        flags[`RSS_ST_DC] = half[4];
        flags[`RSS_ST_OV] = (wval[7] != opnd[7]) && (diff[7] != wval[7]);
        upd = 5'h1F;
      end
      default: begin
        res = opnd;
      end
    endcase
    flags[`RSS_ST_Z] = (res == 8'h00);
    flags[`RSS_ST_N] = res[7];
  end
endmodule

// File: rtl/rss_exec.v
`include "rss_defines.vh"

module rss_exec #(
  parameter POST_W = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire wake_pin,
  output reg osc_stopped
);
  reg [1:0] ctrl_reg;
  reg [7:0] w_reg;
  reg [4:0] stat_reg;
  reg [3:0] bank_reg;
  reg [11:0] index_reg;
  reg [11:0] faddr_reg;
  reg [15:0] ins_reg;
  reg [15:0] ir_reg;
  reg pending_reg;
  reg active_reg;
  reg [1:0] qph_reg;
  reg [7:0] opnd_reg;
  reg [7:0] res_reg;
  reg [4:0] flag_reg;
  reg [4:0] upd_reg;
  reg sleep_reg;
  reg to_n_reg;
  reg pd_n_reg;
  reg [7:0] wdt_reg;
  reg [POST_W-1:0] post_reg;
  reg wake_s1_reg;
  reg wake_s2_reg;
  reg [7:0] fmem [0:4095];

  reg [31:0] rd_next;
  reg err_next;
  wire [2:0] ir_kind;
  wire [11:0] eff_addr;
  wire [7:0] alu_res;
  wire [4:0] alu_flags;
  wire [4:0] alu_upd;
  wire setup;
  wire acc;
  wire wdt_exp;
  wire q4_exec;
  wire wr_file;
  wire slp_go;
  // postscaler step, sized so narrow postscalers stay legal
  localparam [POST_W-1:0] POST_ONE = {POST_W{1'b0}} | 1'b1;

  function [2:0] rss_kind;
    input [15:0] ins;
    begin
      if (ins == `RSS_INS_SLEEP)
        rss_kind = `RSS_K_SLP;
      else if (ins[15:10] == `RSS_OPC_RRC)
        rss_kind = `RSS_K_RRC;
      else if (ins[15:10] == `RSS_OPC_RRN)
        rss_kind = `RSS_K_RRN;
      else if (ins[15:10] == `RSS_OPC_SFB)
        rss_kind = `RSS_K_SFB;
      else if (ins[15:9] == `RSS_OPC_SET)
        rss_kind = `RSS_K_SET;
      else
        rss_kind = `RSS_K_NONE;
    end
  endfunction

  // only the data-moving kinds own a destination
  function rss_has_dest;
    input [2:0] k;
    begin
      rss_has_dest = k != `RSS_K_NONE && k != `RSS_K_SLP;
    end
  endfunction

  assign ir_kind = rss_kind(ir_reg);
  assign setup = psel & ~penable;
  assign acc = psel & penable & pready & ~pslverr;
  assign q4_exec = active_reg && qph_reg == `RSS_Q4;
  // fill-with-ones has no d bit, always goes to the file
  assign wr_file = ir_kind == `RSS_K_SET ||
    (ir_reg[`RSS_BIT_D] && rss_has_dest(ir_kind));
  assign slp_go = q4_exec && ir_kind == `RSS_K_SLP;
  // expiry needs the count and the postscaler both at all ones
  assign wdt_exp = ctrl_reg[`RSS_CTRL_WDE] & (&wdt_reg) & (&post_reg);

  rss_addr u_addr (
    .f_field(ir_reg[7:0]),
    .acc_sel(ir_reg[`RSS_BIT_A]),
    .ext_en(ctrl_reg[`RSS_CTRL_EXT]),
    .bank(bank_reg),
    .index_base(index_reg),
    .file_addr(eff_addr)
  );

  rss_alu u_alu (
    .kind(ir_kind),
    .opnd(opnd_reg),
    .wval(w_reg),
    .cin(stat_reg[`RSS_ST_C]),
    .res(alu_res),
    .flags(alu_flags),
    .upd(alu_upd)
  );

  // read mux and refusal decided in the setup phase
  always @* begin
    rd_next = 32'h0000_0000;
    err_next = 1'b0;
    case (paddr)
      `RSS_OFF_CTRL: rd_next[1:0] = ctrl_reg;
      `RSS_OFF_INSTR: begin
        rd_next[15:0] = ins_reg;
        err_next = pwrite &
          (pending_reg | (rss_kind(pwdata[15:0]) == `RSS_K_NONE));
      end
      `RSS_OFF_WREG: rd_next[7:0] = w_reg;
      `RSS_OFF_STAT: rd_next[4:0] = stat_reg;
      `RSS_OFF_BANK: rd_next[3:0] = bank_reg;
      `RSS_OFF_INDEX: rd_next[11:0] = index_reg;
      `RSS_OFF_PWR: rd_next[4:0] = {pending_reg, active_reg, pd_n_reg,
                                    to_n_reg, sleep_reg};
      `RSS_OFF_FADDR: rd_next[11:0] = faddr_reg;
      `RSS_OFF_FDATA: begin
        rd_next[7:0] = fmem[faddr_reg];
        err_next = pwrite & active_reg;
      end
      `RSS_OFF_WDOG: rd_next[7:0] = wdt_reg;
      default: err_next = 1'b1;
    endcase
  end

  // no wait states: the answer always follows setup by one clock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & err_next;
      if (setup)
        prdata <= err_next ? 32'h0000_0000 : rd_next;
    end
  end

  // plain registers; W, STATUS, INSTR and FDATA live with their users
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `RSS_RST_CTRL;
      bank_reg <= 4'h0;
      index_reg <= 12'h000;
      faddr_reg <= 12'h000;
    end else if (acc && pwrite) begin
      case (paddr)
        `RSS_OFF_CTRL: ctrl_reg <= pwdata[1:0];
        `RSS_OFF_BANK: bank_reg <= pwdata[3:0];
        `RSS_OFF_INDEX: index_reg <= pwdata[11:0];
        `RSS_OFF_FADDR: faddr_reg <= pwdata[11:0];
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // quarter sequencer, frozen while the oscillator is stopped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qph_reg <= `RSS_Q1;
      active_reg <= 1'b0;
      pending_reg <= 1'b0;
      ins_reg <= 16'h0000;
      ir_reg <= 16'h0000;
    end else begin
      if (!sleep_reg)
        qph_reg <= qph_reg + 2'h1;
      if (acc && pwrite && paddr == `RSS_OFF_INSTR) begin
        ins_reg <= pwdata[15:0];
        pending_reg <= 1'b1;
      end else if (!sleep_reg && qph_reg == `RSS_Q1 && pending_reg) begin
        pending_reg <= 1'b0;
      end
      if (!sleep_reg && qph_reg == `RSS_Q1 && pending_reg) begin
        ir_reg <= ins_reg;
        active_reg <= 1'b1;
      end else if (q4_exec) begin
        active_reg <= 1'b0;
      end
    end
  end

  // a bus write to W before Q3 is seen by the running instruction
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opnd_reg <= `RSS_RST_BYTE;
      res_reg <= `RSS_RST_BYTE;
      flag_reg <= `RSS_RST_STAT;
      upd_reg <= `RSS_RST_STAT;
    end else if (active_reg) begin
      if (qph_reg == `RSS_Q2)
        opnd_reg <= fmem[eff_addr];
      if (qph_reg == `RSS_Q3) begin
        res_reg <= alu_res;
        flag_reg <= alu_flags;
        upd_reg <= alu_upd;
      end
    end
  end

  // file store: execution write wins, bus writes refused while busy
  always @(posedge pclk) begin
    if (q4_exec && wr_file)
      fmem[eff_addr] <= res_reg;
    else if (acc && pwrite && paddr == `RSS_OFF_FDATA)
      fmem[faddr_reg] <= pwdata[7:0];
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      w_reg <= `RSS_RST_BYTE;
      stat_reg <= `RSS_RST_STAT;
    end else begin
      if (q4_exec && !wr_file && rss_has_dest(ir_kind))
        w_reg <= res_reg;
      else if (acc && pwrite && paddr == `RSS_OFF_WREG)
        w_reg <= pwdata[7:0];
      // hardware flag update beats a same-cycle bus write
      if (q4_exec)
        stat_reg <= (stat_reg & ~upd_reg) | (flag_reg & upd_reg);
      else if (acc && pwrite && paddr == `RSS_OFF_STAT)
        stat_reg <= pwdata[4:0];
    end
  end

  // watchdog runs from its own source, so it counts during sleep
  // expiry while awake is ignored, no device reset is modelled
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_reg <= 8'h00;
      post_reg <= {POST_W{1'b0}};
    end else if (slp_go) begin
      wdt_reg <= 8'h00;
      post_reg <= {POST_W{1'b0}};
    end else if (ctrl_reg[`RSS_CTRL_WDE]) begin
      wdt_reg <= wdt_reg + 8'h01;
      if (&wdt_reg)
        post_reg <= post_reg + POST_ONE;
    end
  end

  // wake pin is asynchronous: two flops before anything reads it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_s1_reg <= 1'b0;
      wake_s2_reg <= 1'b0;
    end else begin
      wake_s1_reg <= wake_pin;
      wake_s2_reg <= wake_s1_reg;
    end
  end

  // a pin wake lags the pin by three clocks: the two synchroniser flops, then sleep_reg
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_reg <= 1'b0;
      osc_stopped <= 1'b0;
      to_n_reg <= 1'b1;
      pd_n_reg <= 1'b1;
    end else begin
      if (slp_go) begin
        sleep_reg <= 1'b1;
        osc_stopped <= 1'b1;
        to_n_reg <= 1'b1;
        pd_n_reg <= 1'b0;
      end else if (sleep_reg && (wdt_exp || wake_s2_reg)) begin
        sleep_reg <= 1'b0;
        osc_stopped <= 1'b0;
        if (wdt_exp)
          to_n_reg <= 1'b0;
      end
    end
  end
endmodule

// File: dv/rss_exec_asserts.sv
module rss_exec_asserts (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire wake_pin,
  input wire osc_stopped
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  setup_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("answer outside access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("answer held too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without answer");
  unmapped_err_a: assert property (
    psel && !penable && paddr > 12'h024 |=> pslverr)
    else $error("unmapped access not refused");
  refused_zero_a: assert property (pslverr && !pwrite |-> prdata == 0)
    else $error("refused read not zero");
  // the pin passes a two-flop synchroniser before it can wake
  pin_wake_a: assert property (
    osc_stopped && wake_pin |-> ##[1:4] !osc_stopped)
    else $error("pin did not wake");
  sleep_flag_a: assert property (
    pready && !pslverr && !pwrite && paddr == 12'h018
    |-> prdata[0] == $past(osc_stopped))
    else $error("sleep flag disagrees with oscillator");
endmodule

// File: dv/tb.sv
`include "rss_defines.vh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, wake_pin, er;
  logic [11:0] paddr, ad;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, osc_stopped;
  logic [15:0] lf, x, y, z, ins;
  logic [12:0] e;
  logic [7:0] wd, fx;
  int error_cnt, checked, k;
  rss_exec #(.POST_W(1)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wake_pin(wake_pin), .osc_stopped(osc_stopped));
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  task automatic close_out;
    if (error_cnt == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic fail;
    error_cnt++;
    close_out;
  endtask
  task automatic chk(input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    if (pready !== 1'b1) fail;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic run(input logic [15:0] i);
    int n;
    n = 0;
    bus(1'b1, `RSS_OFF_INSTR, {16'h0, i});
    chk({31'h0, er}, 32'h0000_0000);
    do begin
      bus(1'b0, `RSS_OFF_PWR, 32'h0);
      if (n == 0) chk({31'h0, rd[4:3] != 2'b00}, 32'h1);
      n++;
    end while (rd[4:3] !== 2'b00 && n < 10);
    if (rd[4:3] !== 2'b00) fail;
    chk({31'h0, n <= 3}, 32'h0000_0001);
  endtask
  task automatic wait_wake(input int lim);
    int n;
    n = 0;
    while (osc_stopped !== 1'b0 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (osc_stopped !== 1'b0) fail;
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [11:0] faddr(input logic a, ext,
    input logic [7:0] f, input logic [3:0] b, input logic [11:0] ix);
    if (a) return {b, f};
    if (ext && f <= 8'h5F) return ix + {4'h0, f};
    return {(f <= 8'h5F) ? 4'h0 : 4'hF, f};
  endfunction
  function automatic logic [12:0] model(input int k,
    input logic [7:0] w, v, input logic [4:0] st);
    logic [8:0] s;
    logic [4:0] h, f;
    logic [7:0] r;
    f = st;
    case (k)
      0: begin
        r = {st[0], v[7:1]};
        f[0] = v[0];
      end
      1: r = {v[0], v[7:1]};
      2: r = 8'hFF;
      default: begin
        s = {1'b0, w} - {1'b0, v} - {8'h0, ~st[0]};
        h = {1'b0, w[3:0]} - {1'b0, v[3:0]} - {4'h0, ~st[0]};
        r = s[7:0];
        f[0] = ~s[8];
        f[1] = ~h[4];
        f[3] = (w[7] != v[7]) && (r[7] != w[7]);
      end
    endcase
    if (k != 2) begin
      f[2] = (r == 8'h0);
      f[4] = r[7];
    end
    return {f, r};
  endfunction
  initial begin
    {psel, penable, pwrite, wake_pin} <= 4'h0;
    paddr <= 12'h0;
    pwdata <= 32'h0;
    presetn <= 1'b0;
    lf = 16'h0047;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    bus(1'b0, `RSS_OFF_PWR, 32'h0);
    chk(rd, 32'h0000_0006);
    bus(1'b0, 12'h028, 32'h0);
    chk({31'h0, er}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    bus(1'b1, `RSS_OFF_INSTR, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    for (int i = 0; i < 40; i++) begin
      k = i % 4;
      lf = lfsr(lf);
      x = lf;
      lf = lfsr(lf);
      y = lf;
      lf = lfsr(lf);
      z = lf;
      // boundary of the index-relative window, then a full borrow
      if (i < 2) begin
        x[15:8] = 8'h5F + i[7:0];
        y[7:6] = 2'b10;
      end
      if (i == 7) begin
        x[7:0] = 8'h0;
        y = 16'h0;
      end
      ins = k == 2 ? {`RSS_OPC_SET, y[6], x[15:8]} :
        {k == 0 ? `RSS_OPC_RRC : k == 1 ? `RSS_OPC_RRN : `RSS_OPC_SFB,
         y[5], y[6], x[15:8]};
      ad = faddr(y[6], y[7], x[15:8], z[3:0], z[15:4]);
      e = model(k, y[15:8], x[7:0], y[4:0]);
      bus(1'b1, `RSS_OFF_CTRL, {31'h0, y[7]});
      bus(1'b1, `RSS_OFF_BANK, {28'h0, z[3:0]});
      bus(1'b1, `RSS_OFF_INDEX, {20'h0, z[15:4]});
      bus(1'b1, `RSS_OFF_FADDR, {20'h0, ad});
      bus(1'b1, `RSS_OFF_FDATA, {24'h0, x[7:0]});
      bus(1'b1, `RSS_OFF_WREG, {24'h0, y[15:8]});
      bus(1'b1, `RSS_OFF_STAT, {27'h0, y[4:0]});
      run(ins);
      bus(1'b0, `RSS_OFF_WREG, 32'h0);
      chk(rd, {24'h0, (!y[5] && k != 2) ? e[7:0] : y[15:8]});
      bus(1'b0, `RSS_OFF_FDATA, 32'h0);
      fx = (y[5] || k == 2) ? e[7:0] : x[7:0];
      chk(rd, {24'h0, fx});
      bus(1'b0, `RSS_OFF_STAT, 32'h0);
      chk(rd, {27'h0, e[12:8]});
    end
    bus(1'b1, `RSS_OFF_CTRL, 32'h0);
    run(`RSS_INS_SLEEP);
    chk({31'h0, osc_stopped}, 32'h0000_0001);
    bus(1'b0, `RSS_OFF_PWR, 32'h0);
    chk(rd[2:0], 3'b011);
    wake_pin <= 1'b1;
    wait_wake(10);
    wake_pin <= 1'b0;
    bus(1'b0, `RSS_OFF_PWR, 32'h0);
    chk(rd[2:0], 3'b010);
    bus(1'b1, `RSS_OFF_CTRL, 32'h0000_0002);
    repeat (40) @(posedge pclk);
    bus(1'b0, `RSS_OFF_WDOG, 32'h0);
    wd = rd[7:0];
    run(`RSS_INS_SLEEP);
    bus(1'b0, `RSS_OFF_WDOG, 32'h0);
    chk({31'h0, rd[7:0] < wd}, 32'h0000_0001);
    wait_wake(3000);
    bus(1'b0, `RSS_OFF_PWR, 32'h0);
    chk(rd[2:0], 3'b000);
    // reset again mid-run: expiry status must come back clear (to_n_reg reads 1)
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    bus(1'b0, `RSS_OFF_PWR, 32'h0);
    chk(rd, 32'h0000_0006);
    bus(1'b0, `RSS_OFF_CTRL, 32'h0);
    chk(rd, 32'h0000_0000);
    close_out;
  end
endmodule

bind rss_exec rss_exec_asserts chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .wake_pin(wake_pin), .osc_stopped(osc_stopped));
